// ===== phy_misc_map.svh
// Register indices, field positions, reset values and timing figures
// Assumes inclusion by bare name; definitions only
`ifndef PHY_MISC_MAP_SVH
`define PHY_MISC_MAP_SVH

// Register indices; byte address is four times the index
`define IDX_GAIN          16'h0402
`define IDX_CLK_DELAY     16'h0446
`define IDX_DISCHARGE     16'h0448
`define IDX_LIGHT_CFG     16'h0460
`define IDX_IRQ_STATUS    16'h0470
`define IDX_IRQ_MASK      16'h0471

// Field positions
`define GAIN_LSB          0
`define GAIN_RSV_LSB      3
`define TX_DELAY_LSB      4
`define RX_DELAY_LSB      0
`define MAC_COUNT_LSB     8
`define LINE_COUNT_LSB    0
`define LIGHT_RSV_LSB     14
`define BLINK_LSB         12
`define THIRD_SRC_LSB     8
`define SECOND_SRC_LSB    4
`define FIRST_SRC_LSB     0
`define IRQ_MAC_BIT       0
`define IRQ_LINE_BIT      1

// Reset values
`define RST_GAIN          3'h3
`define RST_GAIN_RSV      13'h0070
`define RST_DELAY         4'h7
`define RST_BLINK         2'h2
`define RST_THIRD_SRC     4'h6
`define RST_SECOND_SRC    4'h1
`define RST_FIRST_SRC     4'h0

// Gain codes
`define GAIN_MINUS_60     3'h0
`define GAIN_UNITY        3'h3
`define GAIN_PLUS_80      3'h7

// Indicator source codes
`define SRC_LINK          4'h0
`define SRC_LINK_ACT      4'h1
`define SRC_LINK_TX       4'h2
`define SRC_LINK_RX       4'h3
`define SRC_LINK_LEADER   4'h4
`define SRC_LINK_FOLLOWER 4'h5
`define SRC_ACT           4'h6

// Timing
`define CLK_MHZ           20
`define DELAY_STEP_PS     250
`define BLINK_MS_0        50
`define BLINK_MS_1        100
`define BLINK_MS_2        200
`define BLINK_MS_3        500

`endif

// ===== phy_misc_pkg.sv
// Types shared by the configuration and status register block
// Assumes the map header for all numeric values
package phy_misc_pkg;

    typedef logic [5:0]  count_t;
    typedef logic [3:0]  src_t;
    typedef logic [22:0] tick_t;

    typedef struct packed {
        count_t count;
    } strike_s;

    typedef struct packed {
        tick_t      tick;
        logic       phase;
        logic [2:0] leds;
    } light_s;

    typedef struct packed {
        logic [31:0] rdata;
        logic        ready;
        logic        err;
        logic        irq;
        logic [2:0]  gain;
        logic [12:0] gain_rsv;
        logic [3:0]  tx_dly;
        logic [3:0]  rx_dly;
        logic [1:0]  light_rsv;
        logic [1:0]  blink;
        src_t        third;
        src_t        second;
        src_t        first;
        logic [1:0]  status;
        logic [1:0]  mask;
    } regs_s;

endpackage : phy_misc_pkg

// ===== strike_counter.sv
// Saturating discharge event counter
// Assumes por_n comes only from the power-on detector, never from presetn
`timescale 1ns/10ps
module strike_counter (
    input  wire logic                 pclk,
    input  wire logic                 por_n,
    input  wire logic                 ce,
    input  wire logic                 strike,
    output      phy_misc_pkg::count_t count,
    output      logic                 bump
);
    import phy_misc_pkg::*;

    strike_s r_q;
    strike_s r_d;

    // No dead-time: every enabled cycle with strike high counts until the count is all ones
    assign bump  = ce & strike & ~(&r_q.count);
    assign count = r_q.count;

    always_comb begin
        r_d = r_q;
        if (bump) begin
            r_d.count = r_q.count + count_t'(1); // Stops at all ones
        end
    end

    // Only power cycle clears the count
    always_ff @(posedge pclk or negedge por_n) begin
        if (!por_n) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

endmodule : strike_counter

// ===== indicator_driver.sv
// Indicator light driver: blink timebase and per-light source select
// Assumes status inputs synchronous to pclk
`timescale 1ns/10ps
`include "phy_misc_map.svh"
module indicator_driver #(
    parameter int HALF_0 = 500000,
    parameter int HALF_1 = 1000000,
    parameter int HALF_2 = 2000000,
    parameter int HALF_3 = 5000000
) (
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               ce,
    input  wire logic [1:0]         blink_sel,
    input  wire phy_misc_pkg::src_t first_src,
    input  wire phy_misc_pkg::src_t second_src,
    input  wire phy_misc_pkg::src_t third_src,
    input  wire logic               link_up,
    input  wire logic               tx_activity,
    input  wire logic               rx_activity,
    input  wire logic               is_leader,
    output      logic [2:0]         leds
);
    import phy_misc_pkg::*;

    light_s r_q;
    light_s r_d;
    tick_t  half;

    // Unlisted and reserved codes keep the light dark
    function automatic logic source_out(src_t src, logic link, logic tx, logic rx,
                                        logic lead, logic ph);
        logic act;
        act = tx | rx;
        case (src)
            `SRC_LINK:          source_out = link;
            `SRC_LINK_ACT:      source_out = link & ~(act & ph);
            `SRC_LINK_TX:       source_out = link & ~(tx & ph);
            `SRC_LINK_RX:       source_out = link & ~(rx & ph);
            `SRC_LINK_LEADER:   source_out = link & lead;
            `SRC_LINK_FOLLOWER: source_out = link & ~lead;
            `SRC_ACT:           source_out = act & ph;
            default:            source_out = 1'b0;
        endcase
    endfunction : source_out

    always_comb begin
        case (blink_sel)
            2'h0:    half = tick_t'(HALF_0);
            2'h1:    half = tick_t'(HALF_1);
            2'h2:    half = tick_t'(HALF_2);
            default: half = tick_t'(HALF_3);
        endcase
        r_d = r_q;
        if (ce) begin
            if (r_q.tick >= half - tick_t'(1)) begin
                r_d.tick  = '0;
                r_d.phase = ~r_q.phase;
            end else begin
                r_d.tick = r_q.tick + tick_t'(1);
            end
            r_d.leds[0] = source_out(first_src, link_up, tx_activity, rx_activity,
                                     is_leader, r_q.phase);
            r_d.leds[1] = source_out(second_src, link_up, tx_activity, rx_activity,
                                     is_leader, r_q.phase);
            r_d.leds[2] = source_out(third_src, link_up, tx_activity, rx_activity,
                                     is_leader, r_q.phase);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    assign leds = r_q.leds;

endmodule : indicator_driver

// ===== phy_misc_regs.sv
// Configuration and status registers: line-driver gain, clock-path delays,
// discharge event counters, indicator light setup, event interrupt.
// Assumes an APB master on pclk, and a power-on reset separate from presetn.
//
// Register access over APB was left to the implementer.
`timescale 1ns/10ps
`include "phy_misc_map.svh"
module phy_misc_regs #(
    parameter int ADDR_W = 16,
    parameter int BLINK_HALF_0 = `BLINK_MS_0 * `CLK_MHZ * 500,
    parameter int BLINK_HALF_1 = `BLINK_MS_1 * `CLK_MHZ * 500,
    parameter int BLINK_HALF_2 = `BLINK_MS_2 * `CLK_MHZ * 500,
    parameter int BLINK_HALF_3 = `BLINK_MS_3 * `CLK_MHZ * 500
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              por_n,
    input  wire logic              ce,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output      logic [31:0]       prdata,
    output      logic              pready,
    output      logic              pslverr,
    output      logic              irq,
    input  wire logic              mac_strike,
    input  wire logic              line_strike,
    input  wire logic              link_up,
    input  wire logic              tx_activity,
    input  wire logic              rx_activity,
    input  wire logic              is_leader,
    output      logic [2:0]        gain_code,
    output      logic [3:0]        tx_delay_code,
    output      logic [3:0]        rx_delay_code,
    output      logic [2:0]        indicators
);
    import phy_misc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // State and wires

    regs_s       r_q;
    regs_s       r_d;
    count_t      mac_count;
    count_t      line_count;
    logic        mac_bump;
    logic        line_bump;
    logic [15:0] idx;
    logic        setup;
    logic        access;
    logic [15:0] wmask;
    logic [15:0] wval;
    logic [1:0]  events;
    logic        refused;
    logic        write_hit;
    logic [15:0] rword;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic is_mapped(logic [15:0] i, logic [1:0] lo);
        logic hit;
        hit = (i == `IDX_GAIN) || (i == `IDX_CLK_DELAY) || (i == `IDX_DISCHARGE) ||
              (i == `IDX_LIGHT_CFG) || (i == `IDX_IRQ_STATUS) || (i == `IDX_IRQ_MASK);
        is_mapped = hit && (lo == 2'h0);
    endfunction : is_mapped

    // Only the low two lanes carry register bits
    function automatic logic [15:0] lane_mask(logic [3:0] strb);
        lane_mask = {{8{strb[1]}}, {8{strb[0]}}};
    endfunction : lane_mask

    function automatic logic [15:0] merge(logic [15:0] old, logic [15:0] val,
                                          logic [15:0] m);
        merge = (old & ~m) | (val & m);
    endfunction : merge

    function automatic logic [15:0] read_word(regs_s s, logic [15:0] i,
                                              count_t mac, count_t line);
        logic [15:0] w;
        w = 16'h0000;
        case (i)
            `IDX_GAIN: begin
                w[`GAIN_RSV_LSB +: 13] = s.gain_rsv;
                w[`GAIN_LSB +: 3]      = s.gain;
            end
            `IDX_CLK_DELAY: begin
                w[`TX_DELAY_LSB +: 4] = s.tx_dly;
                w[`RX_DELAY_LSB +: 4] = s.rx_dly;
            end
            `IDX_DISCHARGE: begin
                w[`MAC_COUNT_LSB +: 6]  = mac;
                w[`LINE_COUNT_LSB +: 6] = line;
            end
            `IDX_LIGHT_CFG: begin
                w[`LIGHT_RSV_LSB +: 2]  = s.light_rsv;
                w[`BLINK_LSB +: 2]      = s.blink;
                w[`THIRD_SRC_LSB +: 4]  = s.third;
                w[`SECOND_SRC_LSB +: 4] = s.second;
                w[`FIRST_SRC_LSB +: 4]  = s.first;
            end
            `IDX_IRQ_STATUS: begin
                w[1:0] = s.status;
            end
            `IDX_IRQ_MASK: begin
                w[1:0] = s.mask;
            end
            default: begin
                w = 16'h0000;
            end
        endcase
        read_word = w;
    endfunction : read_word

    ////////////////////////////////////////////////////////////////////////////
    // Discharge counters, on the power-on reset only

    strike_counter u_mac_counter (
        .pclk   (pclk),
        .por_n  (por_n),
        .ce     (ce),
        .strike (mac_strike),
        .count  (mac_count),
        .bump   (mac_bump)
    );

    strike_counter u_line_counter (
        .pclk   (pclk),
        .por_n  (por_n),
        .ce     (ce),
        .strike (line_strike),
        .count  (line_count),
        .bump   (line_bump)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Indicator lights

    indicator_driver #(
        .HALF_0 (BLINK_HALF_0),
        .HALF_1 (BLINK_HALF_1),
        .HALF_2 (BLINK_HALF_2),
        .HALF_3 (BLINK_HALF_3)
    ) u_lights (
        .pclk        (pclk),
        .presetn     (presetn),
        .ce          (ce),
        .blink_sel   (r_q.blink),
        .first_src   (r_q.first),
        .second_src  (r_q.second),
        .third_src   (r_q.third),
        .link_up     (link_up),
        .tx_activity (tx_activity),
        .rx_activity (rx_activity),
        .is_leader   (is_leader),
        .leds        (indicators)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode

    assign idx    = 16'(paddr >> 2);
    assign setup  = psel & ~penable;
    assign access = psel & penable & r_q.ready;
    assign wmask  = lane_mask(pstrb);
    assign wval   = pwdata[15:0];
    assign events[`IRQ_MAC_BIT]  = mac_bump;
    assign events[`IRQ_LINE_BIT] = line_bump;
    // Refused and write accesses answer zero so no field leaks on an error
    assign refused   = ~is_mapped(idx, paddr[1:0]);
    assign rword     = (pwrite || refused) ? 16'h0000 :
                       read_word(r_q, idx, mac_count, line_count);
    assign write_hit = access & pwrite & ~r_q.err;

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        logic [15:0] m;
        logic [1:0]  clr;
        m   = 16'h0000;
        clr = 2'h0;
        r_d = r_q;
        if (ce) begin
            // No wait state: answer is prepared in the setup cycle
            if (setup) begin
                r_d.ready = 1'b1;
                r_d.err   = refused;
                r_d.rdata = {16'h0000, rword};
            end else if (access) begin
                r_d.ready = 1'b0;
                r_d.err   = 1'b0;
                r_d.rdata = 32'h0000_0000;
            end
            if (write_hit) begin
                m = wmask;
                case (idx)
                    `IDX_GAIN: begin
                        {r_d.gain_rsv, r_d.gain} =
                            merge({r_q.gain_rsv, r_q.gain}, wval, m);
                    end
                    `IDX_CLK_DELAY: begin
                        {r_d.tx_dly, r_d.rx_dly} = 8'(merge({8'h00, r_q.tx_dly, r_q.rx_dly},
                                                   wval, m));
                    end
                    `IDX_LIGHT_CFG: begin
                        {r_d.light_rsv, r_d.blink, r_d.third, r_d.second, r_d.first} =
                            merge({r_q.light_rsv, r_q.blink, r_q.third, r_q.second,
                                   r_q.first}, wval, m);
                    end
                    `IDX_IRQ_STATUS: begin
                        clr = wval[1:0] & m[1:0];
                    end
                    `IDX_IRQ_MASK: begin
                        r_d.mask = 2'(merge({14'h0000, r_q.mask}, wval, m));
                    end
                    default: begin
                        m = 16'h0000;
                    end
                endcase
            end
            // New event beats a simultaneous write-one clear
            r_d.status = (r_q.status & ~clr) | events;
            r_d.irq    = |(r_d.status & r_d.mask);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_q           <= '0;
            r_q.gain      <= `RST_GAIN;
            r_q.gain_rsv  <= `RST_GAIN_RSV;
            r_q.tx_dly    <= `RST_DELAY;
            r_q.rx_dly    <= `RST_DELAY;
            r_q.blink     <= `RST_BLINK;
            r_q.third     <= `RST_THIRD_SRC;
            r_q.second    <= `RST_SECOND_SRC;
            r_q.first     <= `RST_FIRST_SRC;
        end else begin
            r_q <= r_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign prdata        = r_q.rdata;
    assign pready        = r_q.ready;
    assign pslverr       = r_q.err;
    assign irq           = r_q.irq;
    assign gain_code     = r_q.gain;
    assign tx_delay_code = r_q.tx_dly;
    assign rx_delay_code = r_q.rx_dly;

endmodule : phy_misc_regs

// ===== phy_misc_regs_sva.sv
// Concurrent checks on the configuration and status register block ports
// Assumes binding into phy_misc_regs, one pclk domain, presetn as reset
`timescale 1ns/10ps
module phy_misc_regs_chk (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        ce,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        irq,
    input wire logic        mac_strike,
    input wire logic        line_strike,
    input wire logic [2:0]  gain_code,
    input wire logic [3:0]  tx_delay_code,
    input wire logic [3:0]  rx_delay_code,
    input wire logic [2:0]  indicators
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    ////////////////////////////////////////////////////////////////////////////
    AST_READY_AFTER_SETUP: assert property (psel && !penable && ce |=> pready)
        else $error("pready missing after setup");
    AST_READY_ONE_CYCLE: assert property (pready && ce |=> !pready)
        else $error("pready held longer than one cycle");
    AST_NO_READY_IDLE: assert property (!psel && ce |=> !pready)
        else $error("pready without a request");
    AST_ERR_ZERO_DATA: assert property (pready && pslverr |-> prdata == 32'h0)
        else $error("refused access returned data");
    AST_UPPER_ZERO: assert property (pready |-> prdata[31:16] == 16'h0)
        else $error("upper read data not zero");
    // Gain and delay fields move only through a bus write, never on their own
    AST_GAIN_HELD: assert property (!(psel && penable && pwrite) |=> $stable(gain_code))
        else $error("gain changed without a write");
    AST_DELAY_HELD: assert property (!(psel && penable && pwrite) |=>
        $stable(tx_delay_code) && $stable(rx_delay_code))
        else $error("delay changed without a write");
    AST_RESET_VALUES: assert property ($rose(presetn) |-> gain_code == 3'h3 &&
        tx_delay_code == 4'h7 && rx_delay_code == 4'h7)
        else $error("field reset values wrong");
    AST_IRQ_CAUSE: assert property ($rose(irq) |-> $past(mac_strike || line_strike) ||
        $past(psel && penable && pwrite))
        else $error("interrupt rose without a cause");

    cover property (pready && pslverr);
    cover property ($rose(irq));
    cover property (indicators[2] && indicators[0]);
endmodule : phy_misc_regs_chk

bind phy_misc_regs phy_misc_regs_chk chk (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .mac_strike(mac_strike), .line_strike(line_strike), .gain_code(gain_code),
    .tx_delay_code(tx_delay_code), .rx_delay_code(rx_delay_code), .indicators(indicators)
);

// ===== testbench.sv
// Self-checking bench for the configuration and status register block
// Assumes an APB slave that answers in its own time; ce dropped only while bus idle
`timescale 1ns/10ps
`include "phy_misc_map.svh"
module testbench;
    localparam logic [15:0] A_GAIN = 16'(`IDX_GAIN * 4);
    localparam logic [15:0] A_DLY  = 16'(`IDX_CLK_DELAY * 4);
    localparam logic [15:0] A_CNT  = 16'(`IDX_DISCHARGE * 4);
    localparam logic [15:0] A_LIT  = 16'(`IDX_LIGHT_CFG * 4);
    localparam logic [15:0] A_STA  = 16'(`IDX_IRQ_STATUS * 4);
    localparam logic [15:0] A_MSK  = 16'(`IDX_IRQ_MASK * 4);
    logic        pclk, presetn, por_n, psel, penable, pwrite;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  pstrb, tx_delay_code, rx_delay_code;
    logic        pready, pslverr, irq, mac_strike, line_strike, er;
    logic        link_up, tx_activity, rx_activity, is_leader, ce;
    logic [2:0]  gain_code, indicators;
    int          n_mismatch = 0;
    int          compares = 0;

    // Short blink half periods keep the light scenario brief
    phy_misc_regs #(.BLINK_HALF_0(4), .BLINK_HALF_1(8), .BLINK_HALF_2(16), .BLINK_HALF_3(32)) dut (
        .pclk(pclk), .presetn(presetn), .por_n(por_n), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .mac_strike(mac_strike), .line_strike(line_strike), .link_up(link_up),
        .tx_activity(tx_activity), .rx_activity(rx_activity), .is_leader(is_leader),
        .gain_code(gain_code), .tx_delay_code(tx_delay_code), .rx_delay_code(rx_delay_code),
        .indicators(indicators)
    );

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic print_verdict;
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : print_verdict

    // Request held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the watchdog ends a wait that never gets its answer
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdchk(input string what, input logic [15:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(what, rd, exp);
    endtask : rdchk

    task automatic strike(input logic mac, input int n);
        @(posedge pclk);
        mac_strike <= mac;
        line_strike <= !mac;
        repeat (n) @(posedge pclk);
        mac_strike <= 1'b0;
        line_strike <= 1'b0;
    endtask : strike

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset_values;
        rdchk("gain word", A_GAIN, 32'h0000_0383);
        rdchk("delay word", A_DLY, 32'h0000_0077);
        rdchk("counts", A_CNT, 32'h0);
        rdchk("lights", A_LIT, 32'h0000_2610);
        rdchk("mask", A_MSK, 32'h0);
        check("gain port", {29'h0, gain_code}, 32'h3);
    endtask : t_reset_values

    task automatic t_fields;
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, A_GAIN, 32'h380 | 32'(i));
            rdchk("gain rw", A_GAIN, 32'h380 | 32'(i));
            check("gain port", {29'h0, gain_code}, 32'(i));
        end
        pstrb <= 4'h1;
        apb(1'b1, A_GAIN, 32'hFF05);
        pstrb <= 4'hF;
        rdchk("gain lane", A_GAIN, 32'h0000_0305);
        for (int i = 0; i < 16; i++) begin
            apb(1'b1, A_DLY, 32'hAB00 | 32'(i * 16 + 15 - i));
            rdchk("delay rw", A_DLY, 32'(i * 16 + 15 - i));
            check("tx port", {28'h0, tx_delay_code}, 32'(i));
            check("rx port", {28'h0, rx_delay_code}, 32'(15 - i));
        end
        apb(1'b1, A_LIT, 32'hFFFF);
        rdchk("lights rw", A_LIT, 32'h0000_FFFF);
    endtask : t_fields

    task automatic t_counters;
        strike(1'b0, 3);
        rdchk("line count", A_CNT, 32'h0003);
        check("irq masked", {31'h0, irq}, 32'h0);
        strike(1'b1, 1);
        rdchk("mac count", A_CNT, 32'h0103);
        rdchk("count reread", A_CNT, 32'h0103);
        rdchk("status", A_STA, 32'h3);
        apb(1'b1, A_MSK, 32'h3);
        repeat (2) @(posedge pclk);
        check("irq raised", {31'h0, irq}, 32'h1);
        apb(1'b1, A_STA, 32'h3);
        repeat (2) @(posedge pclk);
        check("irq cleared", {31'h0, irq}, 32'h0);
        rdchk("status clr", A_STA, 32'h0);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rdchk("count kept", A_CNT, 32'h0103);
        strike(1'b0, 70);
        rdchk("saturated", A_CNT, 32'h013F);
        @(posedge pclk);
        por_n <= 1'b0;
        repeat (2) @(posedge pclk);
        por_n <= 1'b1;
        rdchk("power cycle", A_CNT, 32'h0);
        ce <= 1'b0;
        strike(1'b1, 2);
        ce <= 1'b1;
        rdchk("frozen", A_CNT, 32'h0);
    endtask : t_counters

    task automatic t_errors;
        apb(1'b0, 16'h0000, 32'h0);
        check("unmapped err", {31'h0, er}, 32'h1);
        apb(1'b0, A_GAIN + 16'h1, 32'h0);
        check("unaligned err", {31'h0, er}, 32'h1);
        check("unaligned data", rd, 32'h0);
        apb(1'b1, A_CNT, 32'hFFFF);
        rdchk("counts read only", A_CNT, 32'h0);
    endtask : t_errors

    task automatic t_lights;
        logic hi, lo;
        hi = 1'b0;
        lo = 1'b0;
        apb(1'b1, A_LIT, 32'h0610);
        link_up <= 1'b1;
        repeat (3) @(posedge pclk);
        check("link lights", {29'h0, indicators}, 32'h3);
        tx_activity <= 1'b1;
        // Activity light must follow the blink phase both ways
        repeat (40) begin
            @(posedge pclk);
            hi = hi | (indicators[2] === 1'b1);
            lo = lo | (indicators[2] === 1'b0);
        end
        check("activity blink", {30'h0, hi, lo}, 32'h3);
        check("first steady", {31'h0, indicators[0]}, 32'h1);
        tx_activity <= 1'b0;
        apb(1'b1, A_LIT, 32'h0617);
        repeat (3) @(posedge pclk);
        check("reserved dark", {31'h0, indicators[0]}, 32'h0);
        link_up <= 1'b0;
        repeat (3) @(posedge pclk);
        check("link lost", {29'h0, indicators}, 32'h0);
        apb(1'b1, A_LIT, 32'h0543);
        link_up <= 1'b1;
        is_leader <= 1'b1;
        repeat (3) @(posedge pclk);
        check("leader lights", {29'h0, indicators}, 32'h3);
        is_leader <= 1'b0;
        rx_activity <= 1'b1;
        lo = 1'b0;
        repeat (40) begin
            @(posedge pclk);
            lo = lo | (indicators[0] === 1'b0);
        end
        check("rx blink", {31'h0, lo}, 32'h1);
        check("follower lights", {30'h0, indicators[2:1]}, 32'h2);
        rx_activity <= 1'b0;
    endtask : t_lights

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    initial begin
        repeat (20000) @(posedge pclk);
        n_mismatch++;
        print_verdict();
    end

    initial begin
        presetn = 1'b0;
        por_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 16'h0;
        pwdata = 32'h0;
        pstrb = 4'hF;
        mac_strike = 1'b0;
        line_strike = 1'b0;
        link_up = 1'b0;
        tx_activity = 1'b0;
        rx_activity = 1'b0;
        is_leader = 1'b0;
        ce = 1'b1;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        por_n <= 1'b1;
        t_reset_values();
        t_fields();
        t_counters();
        t_errors();
        t_lights();
        print_verdict();
    end
endmodule : testbench
